// File: sld_pkg.sv
// package for the segment latch display driver: load kinds, display states,
// segment decoder, latch map layout and multiplex timing counts.
// assumes a 32768 Hz pre-divider tick arriving as a one-cycle strobe.
package sld_pkg;

	localparam int SLD_BUS_W = 8;
	localparam int SLD_STB_N = 32;
	localparam int SLD_SEG_N = 27;
	localparam int SLD_COM_N = 5;
	localparam int SLD_LATCH_MAX = 175;
	localparam int SLD_LATCH_N = SLD_SEG_N * SLD_COM_N;
	localparam int SLD_MAP_STB_LSB = 0;
	localparam int SLD_MAP_BUS_LSB = 5;

	// per-pin configuration code field
	localparam logic [3:0] SLD_PIN_DC_PP = 4'h0;
	localparam logic [3:0] SLD_PIN_DISP = 4'h1;
	localparam logic [3:0] SLD_PIN_DC_OD = 4'h9;

	localparam logic [7:0] SLD_BUS_RESET = 8'h00;
	localparam logic [7:0] SLD_BUS_BLANK = 8'h00;

	// alternating rates, slow / typical / fast
	localparam int SLD_PREDIV_HZ = 32768;
	localparam int SLD_HZ_D2[3] = '{32, 64, 128};
	localparam int SLD_HZ_D3[3] = '{43, 84, 120};
	localparam int SLD_HZ_D4[3] = '{32, 64, 128};
	localparam int SLD_HZ_D5[3] = '{51, 102, 205};
	localparam int SLD_TICK_W = 10;

	typedef enum logic [1:0] {
		SLD_LOAD_DECODED = 2'h0,
		SLD_LOAD_BLANK = 2'h1,
		SLD_LOAD_RAW = 2'h2,
		SLD_LOAD_TABLE = 2'h3
	} sld_load_t;

	typedef enum logic [2:0] {
		SLD_DISP_INIT = 3'h1,
		SLD_DISP_ON = 3'h2,
		SLD_DISP_OFF = 3'h4
	} sld_disp_t;

	// pre-divider ticks per common phase; static uses the duplex rate
	function automatic logic [SLD_TICK_W-1:0] sld_phase_ticks(input int duty, input int speed);
		int hz;
		hz = SLD_HZ_D2[speed];
		case (duty)
			3: hz = SLD_HZ_D3[speed];
			4: hz = SLD_HZ_D4[speed];
			5: hz = SLD_HZ_D5[speed];
			default: hz = SLD_HZ_D2[speed];
		endcase
		return SLD_TICK_W'(SLD_PREDIV_HZ / (hz * ((duty < 2) ? 2 : duty)));
	endfunction : sld_phase_ticks

	// seven-segment decoder, lines A..H in bits 0..7
	function automatic logic [7:0] sld_decode(input logic [3:0] nib, input logic seven_f);
		logic [7:0] pat;
		case (nib)
			4'h0: pat = 8'hBF;
			4'h1: pat = 8'h86;
			4'h2: pat = 8'hDB;
			4'h3: pat = 8'hCF;
			4'h4: pat = 8'hE6;
			4'h5: pat = 8'hED;
			4'h6: pat = 8'hFD;
			4'h7: pat = {2'h2, seven_f, 5'h07};
			4'h8: pat = 8'hFF;
			4'h9: pat = 8'hEF;
			default: pat = 8'h00;
		endcase
		return pat;
	endfunction : sld_decode

	// default map: latch i takes bus line i mod 8 and strobe i div 8
	function automatic logic [SLD_LATCH_N-1:0][7:0] sld_default_map();
		logic [SLD_LATCH_N-1:0][7:0] m;
		for (int i = 0; i < SLD_LATCH_N; i++) begin
			m[i] = {3'(i % 8), 5'(i / 8)};
		end
		return m;
	endfunction : sld_default_map

endpackage : sld_pkg

// File: sld_segment_latch_display_driver.sv
// segment latch display driver: bus source selection, latch array,
// blanking, stop grounding, common multiplexing and DC pin outputs.
// assumes the core presents one load request per cycle on the same clock.
// Function
// - decoded and blanking loads pass the chosen nibble through the segment decoder.
// - blanking load of nibble zero puts all zeros on the bus.
// - raw load puts nibble on lines A-D and accumulator on E-H.
// - table load puts table word bits 0-7 on lines A-H.
// - eight bus lines and thirty-two strobes feed every latch.
// - each segment pin has five latches, one shown per common phase.
// - build-time map picks bus line and strobe for each latch.
// - the five-bit select field fires the strobe of that index.
// - display off blanks outputs, on restores them, latches untouched.
// - loads still update latches while blanked, shown when turned on.
// - stop state drives every common and display segment output to ground; DC pins are not grounded.
// - LED mode uses all 27 segment and 5 common pins as LED drives.
// - LED commons active high or low, static to one-fifth duty.
// - LED segment outputs are active low only.
// - half and quarter duty alternate at 32, 64 or 128 Hz.
// - third duty alternates at 43, 84 or 120 Hz.
// - fifth duty alternates at 51, 102 or 205 Hz.
// - pin code 0 is push-pull DC output, code 9 open-drain DC.
// - DC output pins keep their data in stop and display off.
// - outside stop, outputs stay unlit from reset until the first latch load.
// - decoder maps 0-9 to fixed patterns with H high, A-F to zero.
// - build option sets line F of the digit seven pattern.
`timescale 1ns/1ps
`default_nettype none

module sld_segment_latch_display_driver #(
	parameter bit LED_MODE = 1'b1,
	parameter bit COM_ACTIVE_HIGH = 1'b0,
	parameter int DUTY = 5,
	parameter int SPEED = 1,
	parameter bit SEVEN_F_ON = 1'b1,
	parameter logic [sld_pkg::SLD_LATCH_N-1:0][7:0] LATCH_MAP = sld_pkg::sld_default_map(),
	parameter logic [sld_pkg::SLD_SEG_N-1:0][3:0] PIN_CFG = {sld_pkg::SLD_SEG_N{sld_pkg::SLD_PIN_DISP}}
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// timing base
	input wire logic prediv_tick_i,
	input wire logic stop_i,
	// latch load request
	input wire logic load_valid_i,
	input wire sld_pkg::sld_load_t load_kind_i,
	input wire logic [4:0] latch_select_i,
	input wire logic [3:0] nibble_i,
	input wire logic [3:0] acc_i,
	input wire logic [7:0] table_rom_word_i,
	// display on/off commands
	input wire logic display_off_cmd_i,
	input wire logic display_on_cmd_i,
	// panel pins
	output logic [sld_pkg::SLD_SEG_N-1:0] seg_o,
	output logic [sld_pkg::SLD_SEG_N-1:0] seg_oe_o,
	output logic [sld_pkg::SLD_COM_N-1:0] com_o,
	// status
	output logic display_blank_o,
	output logic [sld_pkg::SLD_BUS_W-1:0] seg_data_bus_o
);
	import sld_pkg::*;

	localparam logic [SLD_TICK_W-1:0] PHASE_TICKS = sld_phase_ticks(DUTY, SPEED);
	localparam logic [2:0] PHASE_LAST = 3'(DUTY - 1);
	localparam logic SEG_UNLIT = LED_MODE;

	sld_disp_t disp_reg;
	sld_disp_t disp_next;
	logic [SLD_LATCH_N-1:0] latch_reg;
	logic [SLD_LATCH_N-1:0] latch_next;
	logic [SLD_TICK_W-1:0] tick_reg;
	logic [SLD_TICK_W-1:0] tick_next;
	logic [2:0] phase_reg;
	logic [2:0] phase_next;
	logic [SLD_SEG_N-1:0] seg_reg;
	logic [SLD_SEG_N-1:0] seg_next;
	logic [SLD_SEG_N-1:0] seg_oe_reg;
	logic [SLD_SEG_N-1:0] seg_oe_next;
	logic [SLD_COM_N-1:0] com_reg;
	logic [SLD_COM_N-1:0] com_next;
	logic [SLD_BUS_W-1:0] bus_reg;

	// source selection onto the segment data bus
	wire [7:0] decoded_w = sld_decode(nibble_i, SEVEN_F_ON);
	wire blank_zero_w = (load_kind_i == SLD_LOAD_BLANK) && (nibble_i == 4'h0);
	wire [7:0] raw_w = {acc_i, nibble_i};
	wire [7:0] seg_data_bus = (load_kind_i == SLD_LOAD_RAW) ? raw_w :
		(load_kind_i == SLD_LOAD_TABLE) ? table_rom_word_i :
		blank_zero_w ? SLD_BUS_BLANK : decoded_w;

	// one strobe of the 32 fires per load
	wire [SLD_STB_N-1:0] latch_strobe = load_valid_i ?
		(SLD_STB_N'(1) << latch_select_i) : '0;

	wire tick_wrap_w = prediv_tick_i && (tick_reg == PHASE_TICKS - 1'b1);
	wire phase_wrap_w = (phase_reg >= PHASE_LAST);
	wire blank_w = (disp_reg != SLD_DISP_ON);

	// latch capture through the build-time map
	always_comb begin
		latch_next = latch_reg;
		for (int i = 0; i < SLD_LATCH_N; i++) begin
			if (latch_strobe[LATCH_MAP[i][SLD_MAP_STB_LSB +: 5]]) begin
				latch_next[i] = seg_data_bus[LATCH_MAP[i][SLD_MAP_BUS_LSB +: 3]];
			end
		end
	end

	// display state; off wins if both commands arrive together
	always_comb begin
		disp_next = disp_reg;
		case (disp_reg)
			SLD_DISP_INIT: begin
				if (display_off_cmd_i) begin
					disp_next = SLD_DISP_OFF;
				end else if (load_valid_i) begin
					disp_next = SLD_DISP_ON;
				end
			end
			SLD_DISP_ON: begin
				if (display_off_cmd_i) begin
					disp_next = SLD_DISP_OFF;
				end
			end
			SLD_DISP_OFF: begin
				if (display_on_cmd_i && !display_off_cmd_i) begin
					disp_next = SLD_DISP_ON;
				end
			end
			default: disp_next = SLD_DISP_INIT;
		endcase
	end

	// multiplex timing frozen in stop, when the pre-divider is halted anyway
	always_comb begin
		tick_next = tick_reg;
		phase_next = phase_reg;
		if (!stop_i && prediv_tick_i) begin
			tick_next = tick_wrap_w ? '0 : tick_reg + 1'b1;
			if (tick_wrap_w) begin
				phase_next = phase_wrap_w ? 3'h0 : phase_reg + 3'h1;
			end
		end
	end

	// common drive: outside stop only the current phase is active, inside the duty
	always_comb begin
		com_next = '0;
		for (int k = 0; k < SLD_COM_N; k++) begin
			logic act;
			act = (3'(k) == phase_reg) && (k < DUTY) && !blank_w;
			if (stop_i) begin
				com_next[k] = 1'b0;
			end else if (LED_MODE && !COM_ACTIVE_HIGH) begin
				com_next[k] = !act;
			end else begin
				com_next[k] = act;
			end
		end
	end

	// segment drive per pin
	always_comb begin
		seg_next = '0;
		seg_oe_next = '1;
		for (int s = 0; s < SLD_SEG_N; s++) begin
			logic lit;
			logic dc;
			lit = latch_reg[s * SLD_COM_N + int'(phase_reg)];
			dc = latch_reg[s * SLD_COM_N];
			if (PIN_CFG[s] == SLD_PIN_DC_PP) begin
				seg_next[s] = dc;
			end else if (PIN_CFG[s] == SLD_PIN_DC_OD) begin
				seg_next[s] = 1'b1;
				seg_oe_next[s] = dc;
			end else if (stop_i) begin
				seg_next[s] = 1'b0;
			end else if (blank_w) begin
				seg_next[s] = SEG_UNLIT;
			end else begin
				seg_next[s] = LED_MODE ? !lit : lit;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			disp_reg <= SLD_DISP_INIT;
			latch_reg <= '0;
			tick_reg <= '0;
			phase_reg <= 3'h0;
		end else begin
			disp_reg <= disp_next;
			latch_reg <= latch_next;
			tick_reg <= tick_next;
			phase_reg <= phase_next;
		end
	end

	// outputs come from flops; reset values are unlit levels
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seg_reg <= {SLD_SEG_N{SEG_UNLIT}};
			seg_oe_reg <= '1;
			com_reg <= {SLD_COM_N{LED_MODE && !COM_ACTIVE_HIGH}};
			bus_reg <= SLD_BUS_RESET;
		end else begin
			seg_reg <= seg_next;
			seg_oe_reg <= seg_oe_next;
			com_reg <= com_next;
			bus_reg <= seg_data_bus;
		end
	end

	logic blank_reg;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			blank_reg <= 1'b1;
		end else begin
			blank_reg <= (disp_next != SLD_DISP_ON);
		end
	end

	assign seg_o = seg_reg;
	assign seg_oe_o = seg_oe_reg;
	assign com_o = com_reg;
	assign display_blank_o = blank_reg;
	assign seg_data_bus_o = bus_reg;

	// checks on the bus sources
	wire dec_kind_w = (load_kind_i == SLD_LOAD_DECODED) || (load_kind_i == SLD_LOAD_BLANK);

	decode_eight_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(load_valid_i && dec_kind_w && nibble_i == 4'h8) |=> (seg_data_bus_o == 8'hFF))
		else $error("decoded eight not all ones");

	decode_hex_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(load_valid_i && dec_kind_w && nibble_i > 4'h9) |=> (seg_data_bus_o == 8'h00))
		else $error("decoded hex digit not blank");

	blank_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(load_valid_i && load_kind_i == SLD_LOAD_BLANK && nibble_i == 4'h0)
		|=> (seg_data_bus_o == 8'h00))
		else $error("blanking zero not suppressed");

	raw_bus_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(load_valid_i && load_kind_i == SLD_LOAD_RAW)
		|=> (seg_data_bus_o == {$past(acc_i), $past(nibble_i)}))
		else $error("raw load bus mismatch");

	table_bus_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(load_valid_i && load_kind_i == SLD_LOAD_TABLE)
		|=> (seg_data_bus_o == $past(table_rom_word_i)))
		else $error("table load bus mismatch");

	// latch 0 capture and hold
	wire l0_hit_w = load_valid_i && (latch_select_i == LATCH_MAP[0][SLD_MAP_STB_LSB +: 5]);
	wire l0_bit_w = seg_data_bus[LATCH_MAP[0][SLD_MAP_BUS_LSB +: 3]];

	latch_capture_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		l0_hit_w |=> (latch_reg[0] == $past(l0_bit_w)))
		else $error("mapped latch missed its strobe");

	latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!load_valid_i |=> $stable(latch_reg))
		else $error("latches changed without a load");

	off_keeps_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(disp_reg == SLD_DISP_ON && display_off_cmd_i) |=> (display_blank_o && blank_w))
		else $error("display off did not blank");

	off_load_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(disp_reg == SLD_DISP_OFF && l0_hit_w) |=> (latch_reg[0] == $past(l0_bit_w)))
		else $error("load ignored while blanked");

	stop_ground_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		stop_i |=> (com_o == '0))
		else $error("commons not grounded in stop");

	init_unlit_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(disp_reg == SLD_DISP_INIT && !stop_i && PIN_CFG[2] == SLD_PIN_DISP)
		|=> (seg_o[2] == SEG_UNLIT))
		else $error("segment lit before first load");

	dc_stable_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(PIN_CFG[0] == SLD_PIN_DC_PP && $stable(latch_reg[0]) && stop_i)
		|=> (seg_o[0] == $past(latch_reg[0])))
		else $error("DC pin disturbed in stop");

	phase_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(tick_wrap_w && !stop_i && DUTY > 1) |=> (phase_reg != $past(phase_reg)))
		else $error("phase did not advance at period end");

	phase_range_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		phase_reg <= PHASE_LAST)
		else $error("phase outside duty");

	seven_f_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(load_valid_i && dec_kind_w && nibble_i == 4'h7)
		|=> (seg_data_bus_o == {2'h2, SEVEN_F_ON, 5'h07}))
		else $error("digit seven pattern wrong");

	strobe_onehot_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		load_valid_i |-> $onehot(latch_strobe))
		else $error("load fired other than one strobe");

	load_on_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(disp_reg == SLD_DISP_INIT && load_valid_i && !display_off_cmd_i)
		|=> !display_blank_o)
		else $error("first load did not light display");

	// pin 2 samples a display pin, pins 0 and 1 the DC kinds
	wire [SLD_COM_N-1:0] com_act_w = (LED_MODE && !COM_ACTIVE_HIGH) ? ~com_o : com_o;
	wire pin2_lit_w = latch_reg[2 * SLD_COM_N + int'(phase_reg)];

	one_common_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(!stop_i && !blank_w) |=> $onehot(com_act_w))
		else $error("not exactly one common active");

	off_unlit_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(disp_reg == SLD_DISP_OFF && !stop_i && PIN_CFG[2] == SLD_PIN_DISP)
		|=> (seg_o[2] == SEG_UNLIT))
		else $error("segment lit while display off");

	stop_seg_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(stop_i && PIN_CFG[2] == SLD_PIN_DISP) |=> (seg_o[2] == 1'b0))
		else $error("segment not grounded in stop");

	open_drain_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(PIN_CFG[1] == SLD_PIN_DC_OD)
		|=> (seg_o[1] && (seg_oe_o[1] == $past(latch_reg[SLD_COM_N]))))
		else $error("open drain pin wrong drive");

	pin_shows_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(!stop_i && !blank_w && PIN_CFG[2] == SLD_PIN_DISP)
		|=> ((seg_o[2] ^ LED_MODE) == $past(pin2_lit_w)))
		else $error("segment not showing phase latch");

endmodule : sld_segment_latch_display_driver
`default_nettype wire

// File: sld_panel_model.sv
// panel side model: resolves each segment pin from level and enable.
// assumes a pull-down on every segment line, so a released open-drain pin reads 0.
`timescale 1ns/1ps
`default_nettype none

module sld_panel_model
	import sld_pkg::*;
(
	// pins from the driver
	input wire logic [SLD_SEG_N-1:0] seg_i,
	input wire logic [SLD_SEG_N-1:0] seg_oe_i,
	input wire logic [SLD_COM_N-1:0] com_i,
	// resolved levels
	output logic [SLD_SEG_N-1:0] seg_pin_o,
	output logic [SLD_COM_N-1:0] com_pin_o
);
	// released lines fall to the pull-down, never keep the last level
	assign seg_pin_o = seg_i & seg_oe_i;
	assign com_pin_o = com_i;
endmodule : sld_panel_model

`default_nettype wire

// File: sld_segment_latch_display_driver_test.sv
// self-checking bench for the segment latch display driver.
// assumes default latch map, LED active-low, 1/5 duty, typical speed.
`timescale 1ns/1ps
`default_nettype none

module sld_segment_latch_display_driver_test;
	import sld_pkg::*;
	// pin 0 push-pull DC, pin 1 open-drain DC, rest display
	localparam logic [SLD_SEG_N-1:0][3:0] CFG = {{25{SLD_PIN_DISP}}, SLD_PIN_DC_OD, SLD_PIN_DC_PP};
	localparam int PHASE_CYC = 2 * (32768 / (102 * 5));
	logic ref_clk_i = 1'b0, rstn_i = 1'b0, tick = 1'b0, stop = 1'b0, vld = 1'b0;
	logic off = 1'b0, on = 1'b0;
	sld_load_t kind = SLD_LOAD_DECODED;
	logic [4:0] sel = 5'h00;
	logic [3:0] nib = 4'h0, acc = 4'h0;
	logic [7:0] word = 8'h00, bus;
	logic [SLD_SEG_N-1:0] seg, oe, pin;
	logic [SLD_COM_N-1:0] com, com_pin;
	logic blank;
	int miscompares = 0, checks = 0;
	logic [7:0] dec [16] = '{8'hBF, 8'h86, 8'hDB, 8'hCF, 8'hE6, 8'hED, 8'hFD, 8'hA7,
		8'hFF, 8'hEF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	sld_segment_latch_display_driver #(.PIN_CFG(CFG)) i_sld_segment_latch_display_driver (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .prediv_tick_i(tick), .stop_i(stop),
		.load_valid_i(vld), .load_kind_i(kind), .latch_select_i(sel), .nibble_i(nib),
		.acc_i(acc), .table_rom_word_i(word), .display_off_cmd_i(off),
		.display_on_cmd_i(on), .seg_o(seg), .seg_oe_o(oe), .com_o(com),
		.display_blank_o(blank), .seg_data_bus_o(bus));
	sld_panel_model i_sld_panel_model (.seg_i(seg), .seg_oe_i(oe), .com_i(com),
		.seg_pin_o(pin), .com_pin_o(com_pin));

	always #4 ref_clk_i = ~ref_clk_i;
	// pre-divider ticks every other cycle to keep phases short
	always @(negedge ref_clk_i) tick <= ~tick;

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic load(input sld_load_t k, input logic [4:0] s, input logic [3:0] n,
		input logic [3:0] a, input logic [7:0] w);
		kind = k;
		sel = s;
		nib = n;
		acc = a;
		word = w;
		vld = 1'b1;
		cyc(1);
		vld = 1'b0;
		// idle cycle so valid never drops and rises in one step
		cyc(1);
	endtask : load

	task automatic t_reset(input logic [7:0] exp_bus, input logic [1:0] exp_dc);
		chk("reset seg", {(SLD_SEG_N - 2){1'b1}}, seg[SLD_SEG_N-1:2]);
		chk("reset dc", exp_dc, seg[1:0]);
		chk("reset blank", 1'b1, blank);
		chk("reset bus", exp_bus, bus);
	endtask : t_reset

	task automatic t_decode();
		for (int i = 0; i < 16; i++) begin
			load(SLD_LOAD_DECODED, 5'h1F, 4'(i), 4'h0, 8'h00);
			chk("decoded bus", dec[i], bus);
		end
		chk("blank after load", 1'b0, blank);
		load(SLD_LOAD_BLANK, 5'h1F, 4'h0, 4'h0, 8'h00);
		chk("blank zero", 8'h00, bus);
		load(SLD_LOAD_BLANK, 5'h1F, 4'h8, 4'h0, 8'h00);
		chk("blank eight", 8'hFF, bus);
		load(SLD_LOAD_RAW, 5'h1F, 4'h5, 4'hA, 8'h00);
		chk("raw bus", 8'hA5, bus);
		load(SLD_LOAD_TABLE, 5'h1F, 4'h0, 4'h0, 8'h3C);
		chk("table bus", 8'h3C, bus);
	endtask : t_decode

	task automatic t_dc_stop();
		// strobe 0 feeds pin 0 from line A and pin 1 from line F
		load(SLD_LOAD_TABLE, 5'h00, 4'h0, 4'h0, 8'h01);
		load(SLD_LOAD_TABLE, 5'h01, 4'h0, 4'h0, 8'h00);
		cyc(2);
		chk("dc pins", 2'b01, pin[1:0]);
		chk("od enable", 1'b0, oe[1]);
		stop = 1'b1;
		cyc(2);
		chk("stop com", 5'h00, com);
		chk("stop com pin", 5'h00, com_pin);
		chk("stop seg", 25'h0, seg[SLD_SEG_N-1:2]);
		chk("stop dc", 2'b01, pin[1:0]);
		stop = 1'b0;
		cyc(2);
	endtask : t_dc_stop

	task automatic t_off_on();
		off = 1'b1;
		cyc(1);
		off = 1'b0;
		cyc(2);
		chk("off blank", 1'b1, blank);
		chk("off com", 5'h1F, com);
		chk("off seg", 25'h1FFFFFF, seg[SLD_SEG_N-1:2]);
		chk("off dc", 2'b01, pin[1:0]);
		load(SLD_LOAD_TABLE, 5'h00, 4'h0, 4'h0, 8'h01);
		// strobe 1 line C is pin 2, phase 0
		load(SLD_LOAD_TABLE, 5'h01, 4'h0, 4'h0, 8'h04);
		on = 1'b1;
		cyc(1);
		on = 1'b0;
		cyc(2);
		chk("on blank", 1'b0, blank);
	endtask : t_off_on

	task automatic t_mux();
		logic [SLD_COM_N-1:0] last;
		int n;
		for (int p = 0; p < 7; p++) begin
			last = com;
			n = 0;
			while (com === last && n < 1000) begin
				cyc(1);
				n++;
			end
			if (n >= 1000) begin
				chk("phase timeout", 1'b1, 1'b0);
				wrap_up();
			end
			if (p > 1) chk("phase length", PHASE_CYC, n);
			// com and seg leave the same phase edge, so both are settled here
			chk("one common", 1, $countones(~com));
			chk("pin2 level", (com == 5'h1E) ? 1'b0 : 1'b1, seg[2]);
		end
	endtask : t_mux

	initial begin
		cyc(10);
		t_reset(8'h00, 2'b11);
		rstn_i = 1'b1;
		cyc(1);
		// idle inputs decode nibble zero onto the bus; DC pin 0 shows its cleared latch
		t_reset(dec[0], 2'b10);
		t_decode();
		t_dc_stop();
		t_off_on();
		t_mux();
		wrap_up();
	end
endmodule : sld_segment_latch_display_driver_test

`default_nettype wire
